// ===== verilog/epw_host.sv
// Host controller loading one page and polling for completion
`timescale 1ns/10ps
module epw_host #(
    parameter int WAIT_CYCLES = epw_pkg::WAIT_CYC,
    parameter int STROBE_CYCLES = epw_pkg::STROBE_CYC,
    parameter int ACCESS_CYCLES = epw_pkg::ACCESS_CYC
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic load_valid_i,
    input wire logic [epw_pkg::ADDR_W-1:0] load_addr_i,
    input wire logic [epw_pkg::DATA_W-1:0] load_data_i,
    input wire logic load_last_i,
    input wire logic poll_mode_i,
    input wire logic [epw_pkg::DATA_W-1:0] mem_data_i,
    output logic load_ready_o,
    output logic page_err_o,
    output logic done_o,
    output logic [epw_pkg::ADDR_W-1:0] mem_addr_o,
    output logic [epw_pkg::DATA_W-1:0] mem_data_o,
    output logic mem_data_oe_o,
    output logic mem_ce_n_o,
    output logic mem_we_n_o,
    output logic mem_oe_n_o
);
    import epw_pkg::*;

    // All state of the host in one register
    typedef struct packed {
        epw_state_t state;
        logic [31:0] cnt;
        logic [31:0] tmo;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic last;
        logic first;
        logic [ADDR_W-OFS_W-1:0] page;
        logic [DATA_W-1:0] s1;
        logic [DATA_W-1:0] s2;
        logic ready;
        logic err;
        logic done;
        logic oe_data;
        logic ce_n;
        logic we_n;
        logic oe_n;
    } epw_regs_t;

    epw_regs_t r_reg;
    epw_regs_t r_next;

    function automatic logic [ADDR_W-OFS_W-1:0] page_of(input logic [ADDR_W-1:0] a);
        page_of = a[ADDR_W-1:OFS_W]; // [R13]
    endfunction : page_of

    function automatic logic [31:0] count_down(input logic [31:0] c);
        if (c != 32'h0000_0000)
        begin
            count_down = c - 32'h0000_0001;
        end
        else
        begin
            count_down = c;
        end
    endfunction : count_down

    function automatic logic last_tick(input logic [31:0] c);
        last_tick = (c <= 32'h0000_0001);
    endfunction : last_tick

    always_comb
    begin
        r_next = r_reg;
        // Bus data passes two flops before the compare
        r_next.s1 = mem_data_i;
        r_next.s2 = r_reg.s1;
        r_next.done = 1'b0;
        r_next.err = 1'b0;
        // Timers count down and rest at zero
        r_next.cnt = count_down(r_reg.cnt);
        r_next.tmo = count_down(r_reg.tmo);
        case (r_reg.state)
            EPW_IDLE:
            begin
                if (load_valid_i && r_reg.ready)
                begin
                    if (!r_reg.first && page_of(load_addr_i) != r_reg.page)
                    begin
                        r_next.err = 1'b1; // Page change refused [R4]
                    end
                    else
                    begin
                        r_next.addr = load_addr_i; // Any order within page [R2]
                        r_next.data = load_data_i; // Kept copy for polling [R10]
                        r_next.last = load_last_i;
                        r_next.page = page_of(load_addr_i);
                        r_next.ready = 1'b0;
                        r_next.oe_n = 1'b1; // Output strobe high on write [R12]
                        r_next.oe_data = 1'b1;
                        r_next.state = EPW_SETUP;
                    end
                end
            end
            EPW_SETUP:
            begin
                // Address and data set up a cycle ahead of the strobe
                r_next.ce_n = 1'b0;
                r_next.we_n = 1'b0; // Falling strobe latches byte [R12]
                r_next.cnt = 32'(STROBE_CYCLES);
                r_next.state = EPW_STROBE;
            end
            EPW_STROBE:
            begin
                // Strobe width counted from the falling edge
                if (last_tick(r_reg.cnt))
                begin
                    r_next.ce_n = 1'b1;
                    r_next.we_n = 1'b1;
                    r_next.state = EPW_HOLD;
                end
            end
            EPW_HOLD:
            begin
                // Address and data held a cycle past the rising strobe
                r_next.oe_data = 1'b0;
                r_next.first = 1'b0;
                if (!r_reg.last)
                begin
                    r_next.ready = 1'b1; // Next byte of same page [R6]
                    r_next.state = EPW_IDLE;
                end
                else if (poll_mode_i)
                begin
                    r_next.tmo = 32'(WAIT_CYCLES); // Polling bounded by worst case [R11]
                    r_next.state = EPW_POLL;
                end
                else
                begin
                    r_next.cnt = 32'(WAIT_CYCLES); // Fixed wait [R11] [R15]
                    r_next.state = EPW_WAIT;
                end
            end
            EPW_POLL:
            begin
                // Read strobe covers access time and the two sync flops
                r_next.ce_n = 1'b0;
                r_next.oe_n = 1'b0; // Read of last location [R10] [R16]
                r_next.cnt = 32'(ACCESS_CYCLES) + 32'h0000_0002;
                r_next.state = EPW_SAMPLE;
            end
            EPW_SAMPLE:
            begin
                if (last_tick(r_reg.cnt))
                begin
                    r_next.ce_n = 1'b1;
                    r_next.oe_n = 1'b1;
                    // Top bit inverted or lower bits float until finished [R7] [R8] [R9]
                    if (r_reg.s2 == r_reg.data)
                    begin
                        r_next.state = EPW_DONE;
                    end
                    else if (r_reg.tmo == 32'h0000_0000)
                    begin
                        // Worst-case programming time has passed [R11]
                        r_next.state = EPW_DONE;
                    end
                    else
                    begin
                        r_next.state = EPW_POLL;
                    end
                end
            end
            EPW_WAIT:
            begin
                // No reads while waiting out the worst case
                if (last_tick(r_reg.cnt))
                begin
                    r_next.state = EPW_DONE;
                end
            end
            EPW_DONE:
            begin
                // Next byte opens a new page
                r_next.done = 1'b1;
                r_next.first = 1'b1;
                r_next.ready = 1'b1;
                r_next.state = EPW_IDLE;
            end
            default:
            begin
                // Unknown state values return to idle; all eight codes are states
                r_next.state = EPW_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            // Idle bus: strobes high, data bus released
            r_reg <= '{state: EPW_IDLE, cnt: 32'h0000_0000, tmo: 32'h0000_0000,
                       addr: '0, data: '0,
                       last: 1'b0, first: 1'b1, page: '0, s1: '0, s2: '0,
                       ready: 1'b1, err: 1'b0, done: 1'b0, oe_data: 1'b0,
                       ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // Every output comes straight from the state register
    assign load_ready_o = r_reg.ready;
    assign page_err_o = r_reg.err;
    assign done_o = r_reg.done;
    assign mem_addr_o = r_reg.addr;
    assign mem_data_o = r_reg.data;
    assign mem_data_oe_o = r_reg.oe_data;
    assign mem_ce_n_o = r_reg.ce_n;
    assign mem_we_n_o = r_reg.we_n;
    assign mem_oe_n_o = r_reg.oe_n;
endmodule : epw_host

// ===== verilog/epw_pkg.sv
// Constants and types for the page-write host controller
// Function
// (R1) Unloaded bytes of the page keep their old contents across programming.
// (R2) One to 16 bytes of one page per window, any order.
// (R3) A location loaded twice programs only its latest value.
// (R4) Host keeps address bits above the low four fixed during the window.
// (R5) Device keeps the load window open at least 200 us.
// (R6) Slow hosts should load only four or eight bytes per cycle.
// (R7) During programming the top data line reads the inverse of the loaded bit.
// (R8) During programming the lower seven data lines are undefined on read.
// (R9) After programming a read of the last location matches the loaded byte.
// (R10) Host keeps last byte and address, reads until equal.
// (R11) Host may instead wait the maximum programming time before next access.
// (R12) Cycle starts on last falling strobe edge with output strobe high.
// (R13) Upper eight address bits select the page, low bits the byte; the code takes the upper nine of its 13 address bits as the page.
// (R14) After the window the device floats the bus and ignores controls.
// (R15) Internal erase and program takes about five milliseconds.
// (R16) Status reads during programming do not disturb the page.
package epw_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int OFS_W = 4;
    localparam int PAGE_BYTES = 16;
    localparam int CLK_MHZ = 125;
    // Window budget: the 200 us window in clock cycles, not used by the host, which loads as load_valid_i arrives
    localparam int WINDOW_US = 200;
    localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
    localparam int WAIT_MS = 10;
    localparam int WAIT_CYC = WAIT_MS * 1000 * CLK_MHZ;
    // Bus cycle timing: strobe low and read access
    localparam int STROBE_NS = 200;
    localparam int STROBE_CYC = (STROBE_NS + 7) / 8;
    localparam int ACCESS_NS = 250;
    localparam int ACCESS_CYC = (ACCESS_NS + 7) / 8;
    localparam logic [7:0] TOP_BIT = 8'h07;

    typedef enum logic [2:0] {
        EPW_IDLE = 3'b000,
        EPW_SETUP = 3'b001,
        EPW_STROBE = 3'b011,
        EPW_HOLD = 3'b010,
        EPW_POLL = 3'b110,
        EPW_SAMPLE = 3'b111,
        EPW_WAIT = 3'b101,
        EPW_DONE = 3'b100
    } epw_state_t;
endpackage : epw_pkg

// ===== dv/epw_mem_model.sv
// Behavioural page-write memory on the far side of the host
`timescale 1ns/10ps
module epw_mem_model #(parameter int WIN = 800, parameter int PROG = 400) (
    input wire logic sys_clk_i,
    input wire logic [12:0] addr_i,
    input wire logic [7:0] data_i,
    input wire logic ce_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    output logic [7:0] data_o
);
    logic [7:0] m [8192];
    logic [7:0] lat [16];
    logic [15:0] vld = '0;
    logic [8:0] page;
    logic [12:0] la;
    logic [7:0] ld;
    logic we_q = 1'b1;
    int cnt = 0;
    int ph = 0;
    initial for (int i = 0; i < 8192; i++) m[i] = i[7:0] ^ 8'h5a;
    always @(posedge sys_clk_i)
    begin
        we_q <= we_n_i;
        cnt <= cnt + 1;
        if (ph == 1 && cnt == WIN) ph <= 2;
        if (ph == 2 && cnt == WIN + PROG)
        begin
            for (int i = 0; i < 16; i++) if (vld[i]) m[{page, 4'(i)}] <= lat[i];
            vld <= '0;
            ph <= 0;
        end
        if (we_q && !we_n_i && !ce_n_i && oe_n_i && ph < 2)
        begin
            if (ph == 0) page <= addr_i[12:4];
            if (ph == 0) cnt <= 0;
            ph <= 1;
            lat[addr_i[3:0]] <= data_i;
            vld[addr_i[3:0]] <= 1'b1;
            la <= addr_i;
            ld <= data_i;
        end
        if (!oe_n_i && !ce_n_i)
            data_o <= (ph != 0 && addr_i == la) ? {~ld[7], cnt[6:0]} : m[addr_i];
        else
            data_o <= ~data_o;
    end
endmodule : epw_mem_model

// ===== dv/epw_host_chk.sv
// Bus-cycle checks on the host's ports
`timescale 1ns/10ps
module epw_host_chk (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic load_ready_o,
    input wire logic page_err_o,
    input wire logic done_o,
    input wire logic [epw_pkg::ADDR_W-1:0] mem_addr_o,
    input wire logic [epw_pkg::DATA_W-1:0] mem_data_o,
    input wire logic mem_data_oe_o,
    input wire logic mem_ce_n_o,
    input wire logic mem_we_n_o,
    input wire logic mem_oe_n_o
);
    import epw_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    strobe_start_a: assert property ($fell(load_ready_o) |=> !mem_we_n_o && !mem_ce_n_o)
        else $error("write strobe late");
    strobe_hold_a: assert property ($fell(mem_we_n_o) |=>
        (!mem_we_n_o && $stable(mem_addr_o) && $stable(mem_data_o))[*8]) else $error("write unstable");
    write_mode_a: assert property (!mem_we_n_o |-> mem_oe_n_o && mem_data_oe_o)
        else $error("write with output strobe");
    poll_read_a: assert property (!mem_oe_n_o |-> mem_we_n_o && !mem_ce_n_o && !mem_data_oe_o)
        else $error("bad read cycle");
    refuse_write_a: assert property (page_err_o |-> load_ready_o && mem_we_n_o ##1 mem_we_n_o)
        else $error("refused byte written");
    done_pulse_a: assert property (done_o |=> !done_o && mem_oe_n_o)
        else $error("done not a pulse");
endmodule : epw_host_chk
bind epw_host epw_host_chk u_chk (.sys_clk_i, .reset_i, .load_ready_o, .page_err_o, .done_o,
    .mem_addr_o, .mem_data_o, .mem_data_oe_o, .mem_ce_n_o, .mem_we_n_o, .mem_oe_n_o);

// ===== dv/epw_host_bench.sv
// Self-checking bench for the page-write host
`timescale 1ns/10ps
module epw_host_bench;
    import epw_pkg::*;
    logic sys_clk_i = 0, reset_i = 1, load_valid_i = 0, load_last_i = 0, poll_mode_i = 1;
    logic [12:0] load_addr_i = '0;
    logic [7:0] load_data_i = '0, md, mem_data_o, mem_data_i;
    logic [12:0] mem_addr_o;
    logic load_ready_o, page_err_o, done_o, mem_data_oe_o, mem_ce_n_o, mem_we_n_o, mem_oe_n_o;
    int num_errors = 0, cmp_count = 0, cyc = 0;
    assign mem_data_i = mem_data_oe_o ? mem_data_o : md;
    epw_host #(.WAIT_CYCLES(1500)) u_dut (.sys_clk_i, .reset_i, .load_valid_i, .load_addr_i,
        .load_data_i, .load_last_i, .poll_mode_i, .mem_data_i, .load_ready_o, .page_err_o,
        .done_o, .mem_addr_o, .mem_data_o, .mem_data_oe_o, .mem_ce_n_o, .mem_we_n_o, .mem_oe_n_o);
    epw_mem_model u_mem (.sys_clk_i, .addr_i(mem_addr_o), .data_i(mem_data_o), .ce_n_i(mem_ce_n_o),
        .we_n_i(mem_we_n_o), .oe_n_i(mem_oe_n_o), .data_o(md));
    initial forever #4 sys_clk_i = ~sys_clk_i;
    task automatic end_sim;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    always @(posedge sys_clk_i) if (++cyc == 10000) begin num_errors++; end_sim; end
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        cmp_count++;
        if (s !== e) begin num_errors++; $display("mismatch %s exp %h got %h", n, e, s); end
    endtask : chk
    task automatic load(logic [12:0] a, logic [7:0] d, logic l);
        do @(posedge sys_clk_i); while (load_ready_o !== 1'b1);
        {load_valid_i, load_addr_i, load_data_i, load_last_i} <= {1'b1, a, d, l};
        @(posedge sys_clk_i);
        load_valid_i <= 1'b0;
    endtask : load
    task automatic wait_done;
        int n = 0;
        do begin @(posedge sys_clk_i); n++; end while (done_o !== 1'b1 && n < 4000);
        chk("done", 1, done_o);
    endtask : wait_done
    task automatic s_full;
        logic [7:0] e [16];
        for (int i = 0; i < 16; i++)
        begin
            e[(i * 5) % 16] = 8'h80 + 8'(i);
            load({9'h001, 4'((i * 5) % 16)}, e[(i * 5) % 16], 1'b0);
        end
        e[5] = 8'h3c;
        load(13'h0015, 8'h3c, 1'b1);
        wait_done;
        for (int i = 0; i < 16; i++) chk("page byte", e[i], u_mem.m[16 + i]);
    endtask : s_full
    task automatic s_err;
        logic hit = 0;
        load(13'h0050, 8'hc1, 1'b0);
        load(13'h0060, 8'h77, 1'b0);
        repeat (2) begin @(posedge sys_clk_i); hit |= page_err_o === 1'b1; end
        chk("page error", 1, hit);
        load(13'h0052, 8'h9e, 1'b1);
        wait_done;
        chk("first byte", 8'hc1, u_mem.m[13'h0050]);
        chk("skipped byte", 8'h51 ^ 8'h5a, u_mem.m[13'h0051]);
        chk("other page", 8'h60 ^ 8'h5a, u_mem.m[13'h0060]);
    endtask : s_err
    task automatic s_wait;
        poll_mode_i <= 1'b0;
        load(13'h0070, 8'hf0, 1'b1);
        wait_done;
        chk("waited byte", 8'hf0, u_mem.m[13'h0070]);
    endtask : s_wait
    initial
    begin
        repeat (6) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        s_full;
        s_err;
        s_wait;
        end_sim;
    end
endmodule : epw_host_bench
